// ===== sim/fecb_host.sv
// Purpose: host controller model issuing switch commands
// Assumes: shares the device clock
// Notes: allow is meaningless outside valid, so it toggles there
module fecb_host
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic go_in,
   input wire logic allow_req_in,
   output logic valid_out,
   output logic allow_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // one-cycle command; unqualified allow never holds a stale value
   always_ff @(posedge clk_in or negedge rst_n_in)
      if (!rst_n_in)
      begin
         valid_out <= 1'b0;
         allow_out <= 1'b0;
      end
      else
      begin
         valid_out <= go_in;
         allow_out <= go_in ? allow_req_in : ~allow_out;
      end
endmodule

// ===== sim/fecb_top_tb_top.sv
// Purpose: self-checking bench for the fault enable and switch bank
// Assumes: short predischarge count, fixed seed
// Notes: expectations come from bench constants and the exp_sw function
module fecb_top_tb_top
   import fecb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned PC = 6;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, er, se;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, d;
   fecb_fault_t fault = '0;
   fecb_pair_t want = '0, diode = '0;
   logic go = 0, allow_req = 0, hv, ha, sleep = 0, chg, dsg, predischarge_switch, pfl;
   logic [8:0] en, f;
   logic [7:0] opt;
   int fails = 0, n_checks = 0, cyc = 0;
   logic [7:0] ra [3] = '{OFF_INT, OFF_TOS, OFF_OPT};
   logic [31:0] rv [3] = '{32'h0000_0007, 32'h0000_0000, 32'h0000_000d};
   logic [31:0] rm [3] = '{32'h0000_00ff, 32'h0000_0001, 32'h0000_003f};
   fecb_top #(.PREDISCHARGE_SWITCH_CYC(PC)) i_fecb_top (.mclk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(er), .fault_in(fault),
      .host_cmd_valid_in(hv), .host_cmd_allow_in(ha), .sleep_in(sleep), .want_in(want),
      .diode_cur_in(diode), .chg_on_out(chg), .dsg_on_out(dsg),
      .predischarge_switch_out(predischarge_switch), .pf_latched_out(pfl));
   fecb_host i_fecb_host (.clk_in(clk), .rst_n_in(rst_n), .go_in(go), .allow_req_in(allow_req),
      .valid_out(hv), .allow_out(ha));
   // 10 MHz clock
   initial forever #50 clk = ~clk;
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // hang guard, far above the expected run length
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         fails++;
         conclude();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer; the wait is bounded by the hang guard
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      se = er;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic host(input logic a);
      @(posedge clk);
      go <= 1'b1;
      allow_req <= a;
      @(posedge clk);
      go <= 1'b0;
      settle(5);
   endtask
   // {chg, dsg} once settled, no body diode current
   function automatic logic [1:0] exp_sw(logic [7:0] o, logic sl, fecb_pair_t w);
      logic b;
      b = o[BIT_CTRL_EN] & ~o[BIT_INIT_OFF];
      return {b & w.chg & ~(sl & ~o[BIT_SLEEP_CHG]), b & w.dsg};
   endfunction
   initial
   begin
      void'($urandom(32'hb60b5d37));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 3; k++)
      begin
         apb(1'b0, ra[k], '0);
         chk("reset", rd, rv[k]);
         d = $urandom;
         apb(1'b1, ra[k], d);
         apb(1'b0, ra[k], '0);
         chk("readback", rd, d & rm[k]);
      end
      apb(1'b0, 8'h40, '0);
      chk("unmapped err", {31'h0, se}, 32'h0000_0001);
      chk("unmapped data", rd, 32'h0000_0000);
      // escalation only where the cause is enabled
      for (int i = 0; i < 20; i++)
      begin
         en = (i == 0) ? 9'h1ff : 9'($urandom);
         f = (i == 1) ? 9'h1ff : 9'($urandom);
         apb(1'b1, OFF_INT, {24'h0, en[7:0]});
         apb(1'b1, OFF_TOS, {31'h0, en[8]});
         fault <= {f[7:0], f[8]};
         @(posedge clk);
         fault <= '0;
         apb(1'b0, OFF_PF, '0);
         chk("pf", rd, {23'h0, f & en});
         chk("pf out", {31'h0, pfl}, {31'h0, |(f & en)});
         apb(1'b1, OFF_PF, 32'h0000_01ff);
      end
      // random options before any host command; default host state follows bit 5
      for (int i = 0; i < 16; i++)
      begin
         opt = 8'($urandom) & OPT_MASK;
         apb(1'b1, OFF_OPT, {24'h0, opt});
         sleep <= 1'($urandom);
         want <= 2'($urandom);
         settle(PC + 4);
         chk("switches", {29'h0, predischarge_switch, chg, dsg}, {29'h0, 1'b0, exp_sw(opt, sleep, want)});
      end
      apb(1'b1, OFF_OPT, 32'h0000_000d);
      sleep <= 1'b0;
      want <= 2'b10;
      diode <= 2'b01;
      settle(4);
      chk("diode series", {30'h0, chg, dsg}, 32'h0000_0003);
      apb(1'b1, OFF_OPT, 32'h0000_000c);
      settle(4);
      chk("diode parallel", {30'h0, chg, dsg}, 32'h0000_0002);
      apb(1'b1, OFF_OPT, 32'h0000_0018);
      want <= 2'b00;
      diode <= 2'b00;
      settle(3);
      @(posedge clk);
      want <= 2'b01;
      settle(1);
      chk("pre start", {30'h0, predischarge_switch, dsg}, 32'h0000_0002);
      settle(PC - 1);
      chk("pre hold", {30'h0, predischarge_switch, dsg}, 32'h0000_0002);
      settle(1);
      chk("pre end", {30'h0, predischarge_switch, dsg}, 32'h0000_0001);
      apb(1'b1, OFF_OPT, 32'h0000_000c);
      want <= 2'b10;
      host(1'b0);
      chk("host off", {31'h0, chg}, 32'h0000_0000);
      host(1'b1);
      chk("host on", {31'h0, chg}, 32'h0000_0001);
      apb(1'b0, OFF_SW, '0);
      chk("status", rd, 32'h0000_0009);
      apb(1'b1, OFF_OPT, 32'h0000_0008);
      host(1'b0);
      chk("host ignored", {31'h0, chg}, 32'h0000_0001);
      conclude();
   end
endmodule

// ===== src/fecb_pkg.sv
// Purpose: shared constants and types for the fault enable and switch config bank
// Assumes: 10 MHz clock, APB register access, 32-bit data
// Notes: offsets are byte addresses on the low eight address bits
package fecb_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_INT = 8'h00;
   localparam logic [7:0] OFF_TOS = 8'h04;
   localparam logic [7:0] OFF_OPT = 8'h08;
   localparam logic [7:0] OFF_PF = 8'h0c;
   localparam logic [7:0] OFF_SW = 8'h10;
   // reset values
   localparam logic [7:0] RST_INT = 8'h07;
   localparam logic [7:0] RST_TOS = 8'h00;
   localparam logic [7:0] RST_OPT = 8'h0d;
   // options bits 7:6 are reserved and read zero
   localparam logic [7:0] OPT_MASK = 8'h3f;
   // internal fault enable bit positions
   localparam int BIT_CMD = 7;
   localparam int BIT_MUX = 6;
   localparam int BIT_GND = 5;
   localparam int BIT_VREF = 4;
   localparam int BIT_LFO = 3;
   localparam int BIT_IROM = 2;
   localparam int BIT_DROM = 1;
   localparam int BIT_OTP = 0;
   // stack sum enable and its cause bit in the latched failure word
   localparam int BIT_TOS = 0;
   localparam int BIT_PF_TOS = 8;
   // option bit positions
   localparam int BIT_INIT_OFF = 5;
   localparam int BIT_PREDISCHARGE_SWITCH_ENABLE = 4;
   localparam int BIT_CTRL_EN = 3;
   localparam int BIT_HOST_EN = 2;
   localparam int BIT_SLEEP_CHG = 1;
   localparam int BIT_SERIES = 0;
   // predischarge on-time before the discharge switch
   localparam int unsigned PREDISCHARGE_SWITCH_TIME_MS = 50;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned PREDISCHARGE_SWITCH_CYCLES = (PREDISCHARGE_SWITCH_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int TMR_W = 20;

   typedef enum logic [1:0]
   {
      ST_OFF = 2'b00,
      ST_PRE = 2'b01,
      ST_ON = 2'b10
   } fecb_st_t;

   typedef struct packed
   {
      logic [7:0] internal;
      logic stack_sum;
   } fecb_fault_t;

   typedef struct packed
   {
      logic chg;
      logic dsg;
   } fecb_pair_t;

   typedef struct packed
   {
      logic [7:0] int_en;
      logic tos_en;
      logic [7:0] opt;
      logic [8:0] pf;
      logic host_allow;
      logic host_seen;
      fecb_st_t st;
      logic [TMR_W-1:0] tmr;
      logic [31:0] rdata;
      fecb_pair_t sw;
      logic predischarge_switch;
   } fecb_state_t;
endpackage

// ===== src/fecb_top.sv
// Purpose: fault escalation enables and power switch option bank with switch gating
// Assumes: all inputs except the APB pins come from logic on mclk_in
// Notes: pf cause bits are write-one-to-clear; a new fault in the clear cycle wins
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
module fecb_top
   import fecb_pkg::*;
#(
   parameter int unsigned PREDISCHARGE_SWITCH_CYC = PREDISCHARGE_SWITCH_CYCLES
)
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire fecb_fault_t fault_in,
   input wire logic host_cmd_valid_in,
   input wire logic host_cmd_allow_in,
   input wire logic sleep_in,
   input wire fecb_pair_t want_in,
   input wire fecb_pair_t diode_cur_in,
   output logic chg_on_out,
   output logic dsg_on_out,
   output logic predischarge_switch_out,
   output logic pf_latched_out
);

   fecb_state_t s_r;
   fecb_state_t s_nxt;
   logic wr;
   logic setup;
   logic en;
   logic series;
   logic dsg_want;
   logic chg_allowed;
   logic [8:0] hit;
   logic [8:0] clr;

   // address match against one register offset
   function automatic logic at(input logic [7:0] a, input logic [7:0] off);
      at = (a == off);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = at(a, OFF_INT) | at(a, OFF_TOS) | at(a, OFF_OPT) | at(a, OFF_PF) | at(a, OFF_SW);
   endfunction

   // bus strobes; the slave never waits
   assign setup = psel_in & ~penable_in;
   assign wr = psel_in & penable_in & pwrite_in & mapped(paddr_in);
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in & penable_in & ~mapped(paddr_in);
   assign prdata_out = s_r.rdata;

   // a latched failure drops every switch, whatever the options say
   assign en = s_r.opt[BIT_CTRL_EN] & s_r.host_allow & ~(|s_r.pf);
   assign series = s_r.opt[BIT_SERIES];
   assign dsg_want = en & want_in.dsg;
   assign chg_allowed = en & ~(sleep_in & ~s_r.opt[BIT_SLEEP_CHG]);

   // escalation only through enabled causes
   assign hit = {fault_in.stack_sum & s_r.tos_en, fault_in.internal & s_r.int_en};
   assign clr = (wr && at(paddr_in, OFF_PF)) ? pwdata_in[8:0] : 9'h000;

   always_comb
   begin
      s_nxt = s_r;
      // configuration writes
      if (wr && at(paddr_in, OFF_INT))
      begin
         s_nxt.int_en = pwdata_in[7:0];
      end
      if (wr && at(paddr_in, OFF_TOS))
      begin
         s_nxt.tos_en = pwdata_in[BIT_TOS];
      end
      if (wr && at(paddr_in, OFF_OPT))
      begin
         s_nxt.opt = pwdata_in[7:0] & OPT_MASK;
         // until the host speaks, the start-off bit sets the host state
         if (!s_r.host_seen)
         begin
            s_nxt.host_allow = ~pwdata_in[BIT_INIT_OFF];
         end
      end
      // set wins over clear so no fault is lost
      s_nxt.pf = (s_r.pf & ~clr) | hit;
      // host override, dropped when disabled
      if (host_cmd_valid_in && s_r.opt[BIT_HOST_EN])
      begin
         s_nxt.host_allow = host_cmd_allow_in;
         s_nxt.host_seen = 1'b1;
      end
      // read data captured in setup, shown in access
      if (setup)
      begin
         s_nxt.rdata = 32'h0000_0000;
         if (at(paddr_in, OFF_INT))
         begin
            s_nxt.rdata[7:0] = s_r.int_en;
         end
         if (at(paddr_in, OFF_TOS))
         begin
            s_nxt.rdata[BIT_TOS] = s_r.tos_en;
         end
         if (at(paddr_in, OFF_OPT))
         begin
            s_nxt.rdata[7:0] = s_r.opt;
         end
         if (at(paddr_in, OFF_PF))
         begin
            s_nxt.rdata[8:0] = s_r.pf;
         end
         if (at(paddr_in, OFF_SW))
         begin
            s_nxt.rdata[5:0] = {s_r.st, s_r.host_allow, s_r.predischarge_switch, s_r.sw.dsg, s_r.sw.chg};
         end
      end
      // discharge sequencing with optional predischarge
      unique case (s_r.st)
         ST_OFF:
         begin
            s_nxt.tmr = '0;
            if (dsg_want)
            begin
               s_nxt.st = s_r.opt[BIT_PREDISCHARGE_SWITCH_ENABLE] ? ST_PRE : ST_ON;
            end
         end
         ST_PRE:
         begin
            if (!dsg_want)
            begin
               s_nxt.st = ST_OFF;
            end
            else if (s_r.tmr >= TMR_W'(PREDISCHARGE_SWITCH_CYC - 1))
            begin
               s_nxt.st = ST_ON;
            end
            else
            begin
               s_nxt.tmr = s_r.tmr + TMR_W'(1);
            end
         end
         ST_ON:
         begin
            if (!dsg_want)
            begin
               s_nxt.st = ST_OFF;
            end
         end
         default:
         begin
            s_nxt.st = ST_OFF;
         end
      endcase
      // body diode help only in series mode, and only with the partner on
      s_nxt.sw.chg = chg_allowed & (want_in.chg | (series & s_r.sw.dsg & diode_cur_in.chg));
      s_nxt.sw.dsg = (s_nxt.st == ST_ON) | (en & series & s_r.sw.chg & diode_cur_in.dsg);
      s_nxt.predischarge_switch = (s_nxt.st == ST_PRE);
   end

   // single state register
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         s_r <= '0;
         s_r.int_en <= RST_INT;
         s_r.tos_en <= RST_TOS[BIT_TOS];
         s_r.opt <= RST_OPT;
         s_r.host_allow <= ~RST_OPT[BIT_INIT_OFF];
         s_r.st <= ST_OFF;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // switch outputs straight from flops; failure output is the OR of the pf flops
   assign chg_on_out = s_r.sw.chg;
   assign dsg_on_out = s_r.sw.dsg;
   assign predischarge_switch_out = s_r.predischarge_switch;
   assign pf_latched_out = |s_r.pf;

   // checks beside the logic
   sequence pre_phase;
      predischarge_switch_out && !dsg_on_out;
   endsequence

   sequence dsg_follows;
      !predischarge_switch_out && dsg_on_out;
   endsequence

   int_reset_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      $rose(rst_n_in) |-> (s_r.int_en == RST_INT))
      else $error("internal enables not 0x07 after reset");

   cmd_fail_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      fault_in.internal[BIT_CMD] && s_r.int_en[BIT_CMD] |=> s_r.pf[BIT_CMD] && pf_latched_out)
      else $error("enabled commanded failure did not latch");

   lfo_masked_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !s_r.int_en[BIT_LFO] && !s_r.pf[BIT_LFO] |=> !s_r.pf[BIT_LFO])
      else $error("disabled oscillator fault escalated");

   tos_fail_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      fault_in.stack_sum |=> s_r.pf[BIT_PF_TOS] == $past(s_r.tos_en | (s_r.pf[BIT_PF_TOS] & ~clr[BIT_PF_TOS])))
      else $error("stack sum escalation wrong");

   host_off_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !s_r.host_allow |=> !chg_on_out && !dsg_on_out && !predischarge_switch_out)
      else $error("switch on while host state forces off");

   predischarge_switch_order_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      pre_phase ##1 dsg_on_out |-> dsg_follows)
      else $error("predischarge overlaps discharge");

   predischarge_switch_unused_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !s_r.opt[BIT_PREDISCHARGE_SWITCH_ENABLE] && !predischarge_switch_out |=> !predischarge_switch_out)
      else $error("predischarge used while disabled");

   ctrl_off_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !s_r.opt[BIT_CTRL_EN] |=> !chg_on_out && !dsg_on_out && !predischarge_switch_out)
      else $error("switch on with control disabled");

   host_ignore_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      host_cmd_valid_in && !s_r.opt[BIT_HOST_EN] && !wr |=> $stable(s_r.host_allow))
      else $error("host command acted while ignored");

   sleep_chg_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      sleep_in && !s_r.opt[BIT_SLEEP_CHG] |=> !chg_on_out)
      else $error("charge switch on in sleep");

   diode_on_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      series && dsg_on_out && diode_cur_in.chg && chg_allowed |=> chg_on_out)
      else $error("body diode protection missed");

   pf_sticky_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      pf_latched_out && !wr |=> pf_latched_out)
      else $error("failure cleared without a write");

   // every cause escalates when enabled; command, mux and stack sum also checked to stay quiet when not
   mux_fail_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      fault_in.internal[BIT_MUX] && s_r.int_en[BIT_MUX] |=> s_r.pf[BIT_MUX])
      else $error("enabled stuck mux failure did not latch");

   cmd_masked_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !s_r.int_en[BIT_CMD] && !s_r.pf[BIT_CMD] |=> !s_r.pf[BIT_CMD])
      else $error("disabled commanded failure escalated");

   mux_masked_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !s_r.int_en[BIT_MUX] && !s_r.pf[BIT_MUX] |=> !s_r.pf[BIT_MUX])
      else $error("disabled stuck mux failure escalated");

   gnd_fail_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      fault_in.internal[BIT_GND] && s_r.int_en[BIT_GND] |=> s_r.pf[BIT_GND])
      else $error("enabled ground check failure did not latch");

   vref_fail_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      fault_in.internal[BIT_VREF] && s_r.int_en[BIT_VREF] |=> s_r.pf[BIT_VREF])
      else $error("enabled reference failure did not latch");

   lfo_fail_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      fault_in.internal[BIT_LFO] && s_r.int_en[BIT_LFO] |=> s_r.pf[BIT_LFO])
      else $error("enabled oscillator failure did not latch");

   irom_fail_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      fault_in.internal[BIT_IROM] && s_r.int_en[BIT_IROM] |=> s_r.pf[BIT_IROM])
      else $error("enabled instruction memory failure did not latch");

   drom_fail_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      fault_in.internal[BIT_DROM] && s_r.int_en[BIT_DROM] |=> s_r.pf[BIT_DROM])
      else $error("enabled data memory failure did not latch");

   otp_fail_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      fault_in.internal[BIT_OTP] && s_r.int_en[BIT_OTP] |=> s_r.pf[BIT_OTP])
      else $error("enabled one-time memory failure did not latch");

   tos_set_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      fault_in.stack_sum && s_r.tos_en |=> s_r.pf[BIT_PF_TOS])
      else $error("enabled stack sum failure did not latch");

   tos_masked_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !s_r.tos_en && !s_r.pf[BIT_PF_TOS] |=> !s_r.pf[BIT_PF_TOS])
      else $error("disabled stack sum failure escalated");

   pf_off_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      pf_latched_out |=> !chg_on_out && !dsg_on_out && !predischarge_switch_out)
      else $error("switch on with a latched failure");

   // reset values seen at the first edge after release
   tos_reset_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      $rose(rst_n_in) |-> !s_r.tos_en)
      else $error("stack sum enable not zero after reset");

   opt_reset_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      $rose(rst_n_in) |-> (s_r.opt == RST_OPT))
      else $error("options not at reset value after reset");

   host_reset_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      $rose(rst_n_in) |-> (s_r.host_allow == ~RST_OPT[BIT_INIT_OFF]))
      else $error("host state wrong after reset");

   // host state follows the start-off bit until the first accepted command
   init_off_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      wr && at(paddr_in, OFF_OPT) && !s_r.host_seen && !(host_cmd_valid_in && s_r.opt[BIT_HOST_EN])
      |=> s_r.host_allow == !$past(pwdata_in[BIT_INIT_OFF]))
      else $error("start-off bit did not set host state");

   host_take_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      host_cmd_valid_in && s_r.opt[BIT_HOST_EN] |=> s_r.host_allow == $past(host_cmd_allow_in))
      else $error("allowed host command not taken");

   // discharge start with and without the predischarge phase
   predischarge_switch_direct_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !s_r.opt[BIT_PREDISCHARGE_SWITCH_ENABLE] && dsg_want && s_r.st == ST_OFF |=> dsg_on_out && !predischarge_switch_out)
      else $error("discharge did not start directly");

   predischarge_switch_start_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      s_r.opt[BIT_PREDISCHARGE_SWITCH_ENABLE] && dsg_want && s_r.st == ST_OFF && !diode_cur_in.dsg
      |=> predischarge_switch_out && !dsg_on_out)
      else $error("predischarge did not lead discharge");

   predischarge_switch_bound_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      s_r.st == ST_PRE |-> s_r.tmr < TMR_W'(PREDISCHARGE_SWITCH_CYC))
      else $error("predischarge timer overran");

   sleep_ok_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      chg_allowed && want_in.chg |=> chg_on_out)
      else $error("charge switch held off while allowed");

   // body diode help in series mode only
   diode_dsg_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      series && en && chg_on_out && diode_cur_in.dsg |=> dsg_on_out)
      else $error("discharge body diode protection missed");

   parallel_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !series && !want_in.chg |=> !chg_on_out)
      else $error("charge switch helped in parallel mode");

endmodule
